// file: wwd_pkg.sv
package wwd_pkg;

	// ----------------------------------------------------------------
	// Widths and timing
	// ----------------------------------------------------------------
	localparam int          WWD_CNT_W        = 12;
	localparam int          WWD_PSC_W        = 3;
	localparam int          WWD_PDIV_W       = 7;
	localparam int          WWD_RSTC_W       = 5;
	localparam int          WWD_CLK_PERIOD_NS = 10;
	localparam int          WWD_RST_PULSE_NS = 160;
	localparam int          WWD_RST_PULSE_CYC =
		(WWD_RST_PULSE_NS + WWD_CLK_PERIOD_NS - 1) / WWD_CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0]  WWD_OFS_CTRL     = 8'h00;
	localparam logic [7:0]  WWD_OFS_RELOAD   = 8'h04;
	localparam logic [7:0]  WWD_OFS_DELTA    = 8'h08;
	localparam logic [7:0]  WWD_OFS_KEY      = 8'h0C;
	localparam logic [7:0]  WWD_OFS_PROT     = 8'h10;
	localparam logic [7:0]  WWD_OFS_COUNT    = 8'h14;
	localparam logic [7:0]  WWD_OFS_STATUS   = 8'h18;
	localparam logic [7:0]  WWD_OFS_MASK     = 8'h1C;

	// ----------------------------------------------------------------
	// Control and status fields
	// ----------------------------------------------------------------
	localparam int          WWD_CTRL_EN      = 0;
	localparam int          WWD_CTRL_DBGSTOP = 1;
	localparam int          WWD_CTRL_CLKSEL  = 2;
	localparam int          WWD_CTRL_PSC_LSB = 4;
	localparam int          WWD_ST_UNDER     = 0;
	localparam int          WWD_ST_EARLY     = 1;

	// ----------------------------------------------------------------
	// Keys and reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] WWD_KEY_RELOAD   = 32'h0000_5A5A;
	localparam logic [31:0] WWD_KEY_UNLOCK   = 32'h0000_3C3C;
	localparam logic [11:0] WWD_RST_RELOAD   = 12'h0FFF;
	localparam logic [11:0] WWD_RST_DELTA    = 12'h0FFF;
	localparam logic [2:0]  WWD_RST_PSC      = 3'h0;

	// Classic Wishbone request from the master
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wwd_wb_req_t;

	// Whole state of the watchdog
	typedef struct packed {
		logic [1:0]            irc_sync;
		logic [1:0]            xtl_sync;
		logic                  clk_prev;
		logic [WWD_PDIV_W-1:0] pdiv;
		logic [WWD_CNT_W-1:0]  cnt;
		logic                  en;
		logic                  dbg_stop;
		logic                  clk_sel;
		logic [WWD_PSC_W-1:0]  psc;
		logic [WWD_CNT_W-1:0]  reload;
		logic [WWD_CNT_W-1:0]  delta;
		logic                  locked;
		logic [1:0]            status;
		logic [1:0]            mask;
		logic [WWD_RSTC_W-1:0] rst_cnt;
		logic                  sys_rst;
		logic                  irq;
		logic                  ack;
		logic [31:0]           dat;
	} wwd_state_t;

endpackage : wwd_pkg

// file: wwd_top.sv
// The placing of the registers and register access over Wishbone were decided locally.
`timescale 1ns/1ps

module wwd_top #(
	parameter int RST_PULSE_CYC = wwd_pkg::WWD_RST_PULSE_CYC
) (
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	input  wire wwd_pkg::wwd_wb_req_t wb_req_i,
	output logic [31:0]              wb_dat_o,
	output logic                     wb_ack_o,
	input  wire logic                slow_internal_rc_osc_i,
	input  wire logic                slow_external_crystal_osc_i,
	input  wire logic                dbg_halt_i,
	output logic                     sys_rst_o,
	output logic                     irq_o,
	output logic [11:0]              count_o
);
	import wwd_pkg::*;

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (RST_PULSE_CYC < 1 || RST_PULSE_CYC > (1 << WWD_RSTC_W) - 1) begin : g_chk
		$error("RST_PULSE_CYC out of range");
	end
	if (WWD_PDIV_W < (1 << WWD_PSC_W) - 1) begin : g_chk_pdiv
		$error("Prescale divider narrower than the prescale field needs");
	end
	if ($bits(count_o) != WWD_CNT_W) begin : g_chk_cnt
		$error("Count output width differs from the counter width");
	end
	if (WWD_CTRL_PSC_LSB + WWD_PSC_W > 32) begin : g_chk_ctrl
		$error("Prescale field does not fit the control word");
	end

	localparam logic [WWD_RSTC_W-1:0] RST_LEN = RST_PULSE_CYC[WWD_RSTC_W-1:0];

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Merge write data into an old word under byte enables
	function automatic logic [31:0] wwd_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction : wwd_merge

	// Last prescaler count for a divide of two to the power psc
	function automatic logic [WWD_PDIV_W-1:0] wwd_pdiv_top(
		input logic [WWD_PSC_W-1:0] psc);
		logic [WWD_PDIV_W:0] one;
		one = {{WWD_PDIV_W{1'b0}}, 1'b1};
		return WWD_PDIV_W'((one << psc) - one);
	endfunction : wwd_pdiv_top

	// Write request to one register, taken this cycle
	function automatic logic wwd_wr_hit(input logic taken,
		input wwd_wb_req_t req, input logic [7:0] ofs);
		return taken && req.we && req.adr == ofs;
	endfunction : wwd_wr_hit

	// Read value of one register; unmapped offsets read as zero
	function automatic logic [31:0] wwd_read(input logic [7:0] ofs,
		input wwd_state_t st, input logic [31:0] ctrl);
		logic [31:0] res;
		res = '0;
		case (ofs)
			WWD_OFS_CTRL: begin
				res = ctrl;
			end
			WWD_OFS_RELOAD: begin
				res = {20'h0_0000, st.reload};
			end
			WWD_OFS_DELTA: begin
				res = {20'h0_0000, st.delta};
			end
			WWD_OFS_PROT: begin
				res = {31'h0000_0000, st.locked};
			end
			WWD_OFS_COUNT: begin
				res = {20'h0_0000, st.cnt};
			end
			WWD_OFS_STATUS: begin
				res = {30'h0000_0000, st.status};
			end
			WWD_OFS_MASK: begin
				res = {30'h0000_0000, st.mask};
			end
			default: begin
				res = '0;
			end
		endcase
		return res;
	endfunction : wwd_read

	// State after reset: counter and both limits at their top values
	function automatic wwd_state_t wwd_reset_state();
		wwd_state_t st;
		st = '0;
		st.cnt = WWD_RST_RELOAD;
		st.reload = WWD_RST_RELOAD;
		st.delta = WWD_RST_DELTA;
		st.psc = WWD_RST_PSC;
		return st;
	endfunction : wwd_reset_state

	localparam wwd_state_t RST_STATE = wwd_reset_state();

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	wwd_state_t state_ff;
	wwd_state_t nxt_state;

	logic [31:0] ctrl_word;
	logic [31:0] wr_word;
	logic        bus_req;
	logic        wr_ctrl;
	logic        wr_reload;
	logic        wr_delta;
	logic        wr_key;
	logic        wr_prot;
	logic        wr_status;
	logic        wr_mask;
	logic        wd_clk;
	logic        wd_tick;
	logic        pre_tick;
	logic        pdiv_last;
	logic        frozen;
	logic        reload_req;
	logic        ev_under;
	logic        ev_early;
	logic [1:0]  ev_vec;
	logic [1:0]  clr_vec;

	// Control word as software sees it
	always_comb begin
		ctrl_word = '0;
		ctrl_word[WWD_CTRL_EN] = state_ff.en;
		ctrl_word[WWD_CTRL_DBGSTOP] = state_ff.dbg_stop;
		ctrl_word[WWD_CTRL_CLKSEL] = state_ff.clk_sel;
		ctrl_word[WWD_CTRL_PSC_LSB +: WWD_PSC_W] = state_ff.psc;
	end

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	// Write happens on the edge that raises ack
	assign bus_req   = wb_req_i.cyc && wb_req_i.stb && !state_ff.ack;
	assign wr_word   = wb_req_i.dat;
	assign wr_ctrl   = wwd_wr_hit(bus_req, wb_req_i, WWD_OFS_CTRL)
		&& !state_ff.locked;
	assign wr_reload = wwd_wr_hit(bus_req, wb_req_i, WWD_OFS_RELOAD)
		&& !state_ff.locked;
	assign wr_delta  = wwd_wr_hit(bus_req, wb_req_i, WWD_OFS_DELTA)
		&& !state_ff.locked;
	assign wr_key    = wwd_wr_hit(bus_req, wb_req_i, WWD_OFS_KEY)
		&& wb_req_i.sel == 4'hF;
	assign wr_prot   = wwd_wr_hit(bus_req, wb_req_i, WWD_OFS_PROT)
		&& wb_req_i.sel == 4'hF;
	assign wr_status = wwd_wr_hit(bus_req, wb_req_i, WWD_OFS_STATUS)
		&& wb_req_i.sel[0];
	assign wr_mask   = wwd_wr_hit(bus_req, wb_req_i, WWD_OFS_MASK)
		&& wb_req_i.sel[0];

	// ----------------------------------------------------------------
	// Watchdog clock and counting
	// ----------------------------------------------------------------
	// Pick the synchronised slow clock, find its rising edge
	assign wd_clk = state_ff.clk_sel ? state_ff.xtl_sync[1]
		: state_ff.irc_sync[1];
	assign wd_tick = wd_clk && !state_ff.clk_prev;
	assign frozen = state_ff.dbg_stop && dbg_halt_i;
	// Last prescaler step; a smaller psc written mid-count ends it at once
	assign pdiv_last = state_ff.pdiv >= wwd_pdiv_top(state_ff.psc);
	assign pre_tick = state_ff.en && wd_tick && !frozen
		&& pdiv_last;
	assign reload_req = wr_key && wr_word == WWD_KEY_RELOAD;

	// ----------------------------------------------------------------
	// Reset causes and events
	// ----------------------------------------------------------------
	// Early reload and underflow are the two reset causes
	assign ev_early = reload_req && state_ff.en
		&& state_ff.cnt > state_ff.delta;
	assign ev_under = pre_tick && state_ff.cnt == '0
		&& !reload_req;
	assign ev_vec = {ev_early, ev_under};
	assign clr_vec = wr_status ? wr_word[1:0] : 2'h0;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [31:0] tmp;
		tmp = '0;
		nxt_state = state_ff;

		// Two-stage synchronisers for the slow clock pins
		nxt_state.irc_sync = {state_ff.irc_sync[0], slow_internal_rc_osc_i};
		nxt_state.xtl_sync = {state_ff.xtl_sync[0],
			slow_external_crystal_osc_i};
		nxt_state.clk_prev = wd_clk;

		// Prescaler runs only while counting
		if (reload_req || !state_ff.en) begin
			nxt_state.pdiv = '0;
		end else if (wd_tick && !frozen) begin
			if (pdiv_last) begin
				nxt_state.pdiv = '0;
			end else begin
				nxt_state.pdiv = state_ff.pdiv + 1'b1;
			end
		end

		// Counter: reload, underflow wrap, or step down
		if (reload_req) begin
			nxt_state.cnt = state_ff.reload;
		end else if (ev_under) begin
			nxt_state.cnt = state_ff.reload;
		end else if (pre_tick) begin
			nxt_state.cnt = state_ff.cnt - 1'b1;
		end

		// Configuration under protection
		if (wr_ctrl) begin
			tmp = wwd_merge(ctrl_word, wr_word, wb_req_i.sel);
			nxt_state.en = tmp[WWD_CTRL_EN];
			nxt_state.dbg_stop = tmp[WWD_CTRL_DBGSTOP];
			nxt_state.clk_sel = tmp[WWD_CTRL_CLKSEL];
			nxt_state.psc = tmp[WWD_CTRL_PSC_LSB +: WWD_PSC_W];
			// A source switch must not look like a slow clock edge
			nxt_state.clk_prev = tmp[WWD_CTRL_CLKSEL]
				? state_ff.xtl_sync[1] : state_ff.irc_sync[1];
		end
		if (wr_reload) begin
			tmp = wwd_merge({20'h0_0000, state_ff.reload}, wr_word,
				wb_req_i.sel);
			nxt_state.reload = tmp[WWD_CNT_W-1:0];
		end
		if (wr_delta) begin
			tmp = wwd_merge({20'h0_0000, state_ff.delta}, wr_word,
				wb_req_i.sel);
			nxt_state.delta = tmp[WWD_CNT_W-1:0];
		end
		// Unlock key clears protection, any other value sets it
		if (wr_prot) begin
			nxt_state.locked = wr_word != WWD_KEY_UNLOCK;
		end

		// Sticky events: a set wins over a clear in the same cycle
		nxt_state.status = (state_ff.status & ~clr_vec) | ev_vec;
		if (wr_mask) begin
			nxt_state.mask = wr_word[1:0];
		end
		nxt_state.irq = |(nxt_state.status & nxt_state.mask);

		// System reset pulse of fixed length
		if (ev_under || ev_early) begin
			nxt_state.rst_cnt = RST_LEN;
		end else if (state_ff.rst_cnt != '0) begin
			nxt_state.rst_cnt = state_ff.rst_cnt - 1'b1;
		end
		nxt_state.sys_rst = nxt_state.rst_cnt != '0;

		// Bus answer one cycle after the request
		nxt_state.ack = bus_req;
		nxt_state.dat = '0;
		if (bus_req && !wb_req_i.we) begin
			nxt_state.dat = wwd_read(wb_req_i.adr, state_ff, ctrl_word);
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff <= RST_STATE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Outputs straight from the state register
	assign wb_dat_o  = state_ff.dat;
	assign wb_ack_o  = state_ff.ack;
	assign sys_rst_o = state_ff.sys_rst;
	assign irq_o     = state_ff.irq;
	assign count_o   = state_ff.cnt;

endmodule : wwd_top

// file: wwd_assertions.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Port checker for the lockup guard timer
// ----------------------------------------------------------------
module wwd_assertions
	import wwd_pkg::*;
#(
	parameter int RST_PULSE_CYC = 16
) (
	input wire logic                 clk_i,
	input wire logic                 rst_i,
	input wire wwd_pkg::wwd_wb_req_t wb_req_i,
	input wire logic [31:0]          wb_dat_o,
	input wire logic                 wb_ack_o,
	input wire logic                 sys_rst_o,
	input wire logic [11:0]          count_o
);
	logic [4:0] hi_ff;
	logic       key_wr;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Keyed write being acknowledged
	assign key_wr = wb_ack_o && wb_req_i.we && wb_req_i.adr == WWD_OFS_KEY;

	// Length of the current reset pulse
	always_ff @(posedge clk_i) begin
		hi_ff <= (rst_i || !sys_rst_o) ? 5'h00 : hi_ff + 5'h01;
	end

	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_latency: assert property (
		wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	a_ack_cause: assert property (
		wb_ack_o |-> $past(wb_req_i.cyc && wb_req_i.stb))
		else $error("ack without request");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data outside ack");
	a_count_step: assert property (
		count_o != $past(count_o) && $past(count_o) != 12'h000 && !key_wr
		|-> count_o == $past(count_o) - 12'h001)
		else $error("counter moved by other than one");
	a_underflow_rst: assert property (
		$past(count_o) == 12'h000 && count_o != 12'h000 && !key_wr
		|-> sys_rst_o)
		else $error("underflow without system reset");
	a_pulse_max: assert property (sys_rst_o |-> hi_ff < RST_PULSE_CYC)
		else $error("reset pulse too long");
	a_pulse_full: assert property ($fell(sys_rst_o) |-> hi_ff == RST_PULSE_CYC)
		else $error("reset pulse too short");
endmodule : wwd_assertions

bind wwd_top wwd_assertions #(.RST_PULSE_CYC(RST_PULSE_CYC)) u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sys_rst_o(sys_rst_o),
	.count_o(count_o));

// file: tb_top.sv
`timescale 1ns/1ps

module tb_top;
	import wwd_pkg::*;
	logic        clk_i = 0;
	logic        rst_i = 1;
	logic        rc = 0, xt = 0, halt = 0, ack, srst, irq, sp = 0;
	logic [31:0] dat;
	logic [11:0] cnt;
	logic [32:0] exp_q[$];
	wwd_wb_req_t req = '0;
	int          num_errors = 0, comparisons = 0, pulses = 0, cyc_n = 0;

	always #5 clk_i = ~clk_i;

	wwd_top #(.RST_PULSE_CYC(2)) dut (.clk_i(clk_i), .rst_i(rst_i),
		.wb_req_i(req), .wb_dat_o(dat), .wb_ack_o(ack),
		.slow_internal_rc_osc_i(rc), .slow_external_crystal_osc_i(xt),
		.dbg_halt_i(halt), .sys_rst_o(srst), .irq_o(irq), .count_o(cnt));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic complete_run;
		if (num_errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			num_errors++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask : chk

	// Single classic cycle, expected read value noted
	task automatic wb(logic w, logic [7:0] a, logic [31:0] d,
		logic [31:0] e = 32'h0000_0000);
		exp_q.push_back({!w, e});
		req <= '{1'b1, 1'b1, w, a, 4'hF, d};
		do @(posedge clk_i); while (ack !== 1'b1);
		req <= '0;
		@(posedge clk_i);
	endtask : wb

	// Rising edges on one slow clock pin
	task automatic tick(int n, logic x = 0);
		repeat (n) begin
			if (x) xt <= 1; else rc <= 1;
			repeat (4) @(posedge clk_i);
			xt <= 0;
			rc <= 0;
			repeat (4) @(posedge clk_i);
		end
	endtask : tick

	// Read compare, reset pulse count, timeout
	always @(negedge clk_i) begin
		logic [32:0] e;
		if (ack === 1'b1) begin
			e = exp_q.pop_front();
			if (e[32]) chk("rdata", e[31:0], dat);
		end
		if (srst && !sp) pulses++;
		sp = srst;
		cyc_n++;
		if (cyc_n == 5000) begin
			num_errors++;
			complete_run();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		int p;
		logic [11:0] rl;
		void'($urandom(32'h306f_9e37));
		repeat (5) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		for (int a = 0; a <= 32; a += 4)
			wb(0, 8'(a), 0, (a == 4 || a == 8 || a == 20) ? 32'h0000_0FFF : 0);
		p = $urandom_range(3);
		rl = 12'h100 + 12'($urandom_range(255));
		wb(1, WWD_OFS_RELOAD, rl);
		wb(1, WWD_OFS_DELTA, rl);
		wb(1, WWD_OFS_KEY, 32'h0000_1234);
		wb(0, WWD_OFS_COUNT, 0, 32'h0000_0FFF);
		// Reload while disabled, so no window check yet
		wb(1, WWD_OFS_KEY, WWD_KEY_RELOAD);
		wb(0, WWD_OFS_COUNT, 0, rl);
		wb(1, WWD_OFS_CTRL, (p << 4) | 1);
		tick(3 << p);
		wb(0, WWD_OFS_COUNT, 0, rl - 12'h003);
		// Crystal selected, stop in debug halt, prescale one
		wb(1, WWD_OFS_CTRL, 32'h0000_0007);
		tick(4);
		wb(0, WWD_OFS_COUNT, 0, rl - 12'h003);
		wb(1, WWD_OFS_KEY, WWD_KEY_RELOAD);
		tick(2, 1);
		wb(0, WWD_OFS_COUNT, 0, rl - 12'h002);
		halt <= 1;
		tick(2, 1);
		wb(0, WWD_OFS_COUNT, 0, rl - 12'h002);
		halt <= 0;
		tick(1, 1);
		wb(0, WWD_OFS_COUNT, 0, rl - 12'h003);
		// Early reload above delta
		wb(1, WWD_OFS_DELTA, rl - 12'h004);
		wb(1, WWD_OFS_KEY, WWD_KEY_RELOAD);
		wb(0, WWD_OFS_STATUS, 0, 32'h0000_0002);
		chk("irq", 32'h0000_0000, {31'h0000_0000, irq});
		wb(1, WWD_OFS_MASK, 32'h0000_0002);
		chk("irq", 32'h0000_0001, {31'h0000_0000, irq});
		wb(1, WWD_OFS_STATUS, 32'h0000_0002);
		chk("irq", 32'h0000_0000, {31'h0000_0000, irq});
		// Underflow without reload
		wb(1, WWD_OFS_RELOAD, 32'h0000_0002);
		// Window wide open, so this reload is not early
		wb(1, WWD_OFS_DELTA, 32'h0000_0FFF);
		wb(1, WWD_OFS_KEY, WWD_KEY_RELOAD);
		tick(3, 1);
		wb(0, WWD_OFS_STATUS, 0, 32'h0000_0001);
		wb(0, WWD_OFS_COUNT, 0, 32'h0000_0002);
		chk("count_o", 32'h0000_0002, {20'h0_0000, cnt});
		chk("pulses", 2, pulses);
		// Write protection
		wb(1, WWD_OFS_PROT, 32'h0000_0000);
		wb(1, WWD_OFS_RELOAD, 32'h0000_0005);
		wb(1, WWD_OFS_CTRL, 32'h0000_0000);
		wb(0, WWD_OFS_RELOAD, 0, 32'h0000_0002);
		wb(0, WWD_OFS_CTRL, 0, 32'h0000_0007);
		wb(0, WWD_OFS_PROT, 0, 32'h0000_0001);
		wb(1, WWD_OFS_PROT, WWD_KEY_UNLOCK);
		wb(1, WWD_OFS_RELOAD, 32'h0000_0005);
		wb(0, WWD_OFS_RELOAD, 0, 32'h0000_0005);
		complete_run();
	end
endmodule : tb_top
